// *** verilog/djc_pkg.sv ***
// decade johnson counter: shared constants
// assumes a single 250 MHz system clock and pin-level counting inputs
package djc_pkg;

    localparam int unsigned DJC_STAGES      = 5;   // johnson ring length
    localparam int unsigned DJC_MODULUS     = 10;  // count states per cycle
    localparam int unsigned DJC_SYNC_DEPTH  = 2;   // flops per pin synchroniser
    localparam int unsigned DJC_PIN_COUNT   = 3;   // count clock, enable, counter reset
    localparam int unsigned DJC_WARM_CYCLES = 3;   // cycles before edges are trusted

    // pin positions inside the synchronised bus
    localparam int unsigned DJC_PIN_CLK     = 0;
    localparam int unsigned DJC_PIN_EN_N    = 1;
    localparam int unsigned DJC_PIN_RST     = 2;

    typedef logic [DJC_STAGES-1:0] djc_ring_t;

    // ring contents for counts zero to nine
    localparam djc_ring_t DJC_RING_RESET = 5'h00;
    localparam djc_ring_t DJC_RING_CODE [DJC_MODULUS] = '{
        5'h00, 5'h01, 5'h03, 5'h07, 5'h0F,
        5'h1F, 5'h1E, 5'h1C, 5'h18, 5'h10
    };

    // reset value of the pin synchroniser flops
    localparam logic [DJC_PIN_COUNT-1:0] DJC_SYNC_RESET = 3'h0;
    localparam logic [1:0]               DJC_WARM_RESET = 2'h0;

endpackage

// *** verilog/djc_sync_2ff.sv ***
// two-flop synchroniser for a bus of independent pin levels
// assumes each bit is a slow level; no bus coherence is implied
`timescale 1ns/1ps
`default_nettype none
module djc_sync_2ff
    import djc_pkg::*;
#(
    parameter int unsigned WIDTH = DJC_PIN_COUNT
) (
    input  wire logic             clock,
    input  wire logic             reset_n,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] meta_q;

    // first stage feeds only the second stage
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            meta_q   <= WIDTH'(DJC_SYNC_RESET);
            sync_out <= WIDTH'(DJC_SYNC_RESET);
        end else begin
            meta_q   <= async_in;
            sync_out <= meta_q;
        end
    end

endmodule
`default_nettype wire

// *** verilog/djc_counter.sv ***
// decade johnson counter: five-stage ring, ten decoded outputs, carry
// assumes pins arrive asynchronously and are sampled by the 250 MHz clock
`timescale 1ns/1ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
// Operation
// - The count lives in a five-stage twisted ring and all outputs are decoded from it combinationally.
// - With enable low and counter reset low, a rising count clock edge steps the counter once.
// - With enable high, count clock edges are ignored and the state holds.
// - With count clock held high and reset low, a falling enable edge steps the counter once.
// - Counter reset high forces count zero, carry high and all other outputs low while it stays high.
// - Exactly one decoded output is high at a time, each for one count period per cycle.
// - Carry is high for counts zero to four and low for counts five to nine.
// - Carry falls on reaching count five and rises on wrapping to zero or on reset.
// - Carry is a symmetric divide-by-ten square wave, five counts high and five low.
// - A following stage clocks from this carry, advancing once per ten counts on its rising edge.
// - Decoded outputs run in order within a stage and across stages with no gap.
module djc_counter
    import djc_pkg::*;
(
    input  wire logic                   clock,
    input  wire logic                   reset_n,
    input  wire logic                   count_clock_pin,
    input  wire logic                   count_enable_n,
    input  wire logic                   counter_reset,
    output logic      [DJC_MODULUS-1:0] decoded_count_outputs,
    output logic                        ripple_carry_output
);

    ////////////////////////////////////////////////////////////////////////////
    // pin synchronisation

    logic [DJC_PIN_COUNT-1:0] pins_async;
    logic [DJC_PIN_COUNT-1:0] pins_sync;
    logic [DJC_PIN_COUNT-1:0] pins_prev_q;
    logic [1:0]               warm_q;
    logic                     warm_done;

    assign pins_async = {counter_reset, count_enable_n, count_clock_pin};

    djc_sync_2ff #(
        .WIDTH    (DJC_PIN_COUNT)
    ) u_sync (
        .clock    (clock),
        .reset_n  (reset_n),
        .async_in (pins_async),
        .sync_out (pins_sync)
    );

    // previous synchronised levels for edge detection
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            pins_prev_q <= DJC_SYNC_RESET;
        end else begin
            pins_prev_q <= pins_sync;
        end
    end

    // hold off edge detection until the pipeline holds real pin levels
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            warm_q <= DJC_WARM_RESET;
        end else if (!warm_done) begin
            warm_q <= warm_q + 2'h1;
        end
    end

    assign warm_done = (warm_q == 2'(DJC_WARM_CYCLES));

    ////////////////////////////////////////////////////////////////////////////
    // edge qualification

    logic clk_level;
    logic en_n_level;
    logic rst_level;
    logic clk_rise;
    logic en_fall;
    logic advance;

    assign clk_level  = pins_sync[DJC_PIN_CLK];
    assign en_n_level = pins_sync[DJC_PIN_EN_N];
    assign rst_level  = pins_sync[DJC_PIN_RST];

    // only these two edges count; all others and static levels do not
    assign clk_rise = warm_done && clk_level && !pins_prev_q[DJC_PIN_CLK];
    assign en_fall  = warm_done && !en_n_level && pins_prev_q[DJC_PIN_EN_N];

    // rising clock with enable low, or falling enable with clock high
    assign advance = (clk_rise && !en_n_level)
                   || (en_fall && clk_level);

    ////////////////////////////////////////////////////////////////////////////
    // johnson ring

    djc_ring_t ring_q;
    djc_ring_t ring_step;
    logic      ring_legal;

    // shift in the inverted top stage; an illegal pattern falls back to zero
    always_comb begin
        ring_legal = 1'b0;
        for (int k = 0; k < DJC_MODULUS; k++) begin
            if (ring_q == DJC_RING_CODE[k]) begin
                ring_legal = 1'b1;
            end
        end
        if (ring_legal) begin
            ring_step = {ring_q[DJC_STAGES-2:0], ~ring_q[DJC_STAGES-1]};
        end else begin
            ring_step = DJC_RING_RESET;
        end
    end

    // counter reset holds count zero and wins over any edge
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            ring_q <= DJC_RING_RESET;
        end else if (rst_level) begin
            ring_q <= DJC_RING_RESET;
        end else if (advance) begin
            ring_q <= ring_step;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // decode

    // one-hot compare against the ten legal patterns
    always_comb begin
        for (int k = 0; k < DJC_MODULUS; k++) begin
            decoded_count_outputs[k] = (ring_q == DJC_RING_CODE[k]);
        end
    end

    // top stage is low for counts zero to four, high for five to nine
    assign ripple_carry_output = ~ring_q[DJC_STAGES-1];

endmodule
`default_nettype wire

// *** test/djc_checker.sv ***
// port checker for the decade counter
// assumes binding onto djc_counter
`timescale 1ns/1ps
`default_nettype none
module djc_checker
    import djc_pkg::*;
(
    input wire logic                   clock,
    input wire logic                   reset_n,
    input wire logic                   count_clock_pin,
    input wire logic                   count_enable_n,
    input wire logic                   counter_reset,
    input wire logic [DJC_MODULUS-1:0] decoded_count_outputs,
    input wire logic                   ripple_carry_output
);
    wire logic [9:0] d = decoded_count_outputs;
    logic [2:0]      up_q;
    default clocking @(posedge clock); endclocking
    default disable iff (!reset_n);
    // cycles since reset, saturating
    always_ff @(posedge clock) begin
        if (!reset_n)
            up_q <= 3'h0;
        else if (up_q != 3'h7)
            up_q <= up_q + 3'h1;
    end
    one_hot_a: assert property (
        $onehot(d)) else $error("not one-hot");
    carry_decode_a: assert property (
        ripple_carry_output == |d[4:0]) else $error("carry wrong");
    reset_zero_a: assert property (
        counter_reset[*3] |=> d == 10'h001 && ripple_carry_output) else $error("reset missed");
    idle_hold_a: assert property (
        (!counter_reset && $stable(count_clock_pin) && $stable(count_enable_n))[*4] |=> $stable(d))
        else $error("moved idle");
    step_rise_a: assert property (
        (up_q == 3'h7 && !counter_reset && !count_enable_n)[*2] ##0 $rose(count_clock_pin)
        ##1 (!counter_reset)[*2] |=> d == {$past(d[8:0]), $past(d[9])}) else $error("no rise step");
    step_fall_a: assert property (
        (up_q == 3'h7 && !counter_reset && count_clock_pin)[*2] ##0 $fell(count_enable_n)
        ##1 (!counter_reset)[*2] |=> d == {$past(d[8:0]), $past(d[9])}) else $error("no fall step");
    carry_fall_a: assert property (
        $fell(ripple_carry_output) |-> d == 10'h020) else $error("carry fell early");
    wrap_zero_a: assert property (
        $changed(d) && $past(d[9]) |-> d == 10'h001) else $error("no wrap");
endmodule
`default_nettype wire

// *** test/djc_edge_src.sv ***
// upstream count clock source
// assumes requests change off the rising edge
`timescale 1ns/1ps
`default_nettype none
module djc_edge_src #(
    parameter int unsigned HOLD = 4
) (
    input  wire logic clock,
    input  wire logic fire,
    input  wire logic level_hi,
    output logic      count_clock_pin
);
    int unsigned left_q;
    // pin held high HOLD cycles per request
    always_ff @(posedge clock) begin
        if (fire)
            left_q <= HOLD;
        else if (left_q != 0)
            left_q <= left_q - 1;
    end
    assign count_clock_pin = level_hi || left_q != 0;
endmodule
`default_nettype wire

// *** test/decade_johnson_counter_tb.sv ***
// bench: table of steps, then reset cases
// assumes the edge source beside the design
`timescale 1ns/1ps
`default_nettype none
module decade_johnson_counter_tb;
    import djc_pkg::*;
    logic clock = 1'b0, reset_n = 1'b0, fire = 1'b0, level_hi = 1'b0;
    logic count_enable_n = 1'b0, counter_reset = 1'b0;
    logic count_clock_pin, ripple_carry_output;
    logic [9:0] decoded_count_outputs;
    // second stage clocked from the carry, and count-three feedback into reset
    logic fb_on = 1'b0, low = 1'b0;
    logic next_carry;
    logic [9:0] next_decoded;
    wire logic rst_pin = counter_reset | (fb_on & decoded_count_outputs[3]);
    int err_total = 0, checks = 0;
    // step kind (0 rise, 1 enable fall, 2 inhibited), count after
    logic [5:0] rows [13] = '{6'h01, 6'h21, 6'h12, 6'h03, 6'h04, 6'h15, 6'h25,
                              6'h06, 6'h07, 6'h08, 6'h09, 6'h10, 6'h01};
    initial forever #2 clock = ~clock;
    djc_edge_src #(.HOLD(4)) djc_edge_src_i (.clock, .fire, .level_hi, .count_clock_pin);
    djc_counter djc_counter_i (.clock, .reset_n, .count_clock_pin, .count_enable_n,
        .counter_reset(rst_pin), .decoded_count_outputs, .ripple_carry_output);
    djc_counter djc_counter_next_i (.clock, .reset_n, .count_clock_pin(ripple_carry_output),
        .count_enable_n(low), .counter_reset, .decoded_count_outputs(next_decoded),
        .ripple_carry_output(next_carry));
    task automatic idle(int n);
        repeat (n) @(negedge clock);
    endtask
    // compare outputs with count k
    task automatic check_out(int k);
        logic [10:0] exp;
        exp = {10'h001 << k, k < 5};
        checks++;
        if ({decoded_count_outputs, ripple_carry_output} !== exp) begin
            err_total++;
            $display("BAD outputs exp %h got %h", exp, {decoded_count_outputs, ripple_carry_output});
        end
    endtask
    // compare the cascaded stage with count k
    task automatic check_next(int k);
        logic [10:0] exp;
        exp = {10'h001 << k, k < 5};
        checks++;
        if ({next_decoded, next_carry} !== exp) begin
            err_total++;
            $display("BAD next_stage exp %h got %h", exp, {next_decoded, next_carry});
        end
    endtask
    // one step; ends with clock fall and enable fall at clock low
    task automatic step(logic [1:0] m);
        count_enable_n = m[1] | m[0];
        level_hi = m[0];
        fire = !m[0];
        idle(1);
        fire = 1'b0;
        idle(4);
        count_enable_n = m[1];
        idle(8);
        level_hi = 1'b0;
        idle(8);
        count_enable_n = 1'b0;
        idle(4);
    endtask
    task automatic tally_and_finish();
        $display("checks %0d errors %0d", checks, err_total);
        if (err_total == 0 && checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    initial begin
        idle(20);
        reset_n = 1'b1;
        idle(8);
        check_out(0);
        foreach (rows[i]) begin
            step(rows[i][5:4]);
            check_out(rows[i][3:0]);
        end
        check_next(1);
        // counter reset against a rising edge
        counter_reset = 1'b1;
        fire = 1'b1;
        idle(1);
        fire = 1'b0;
        idle(9);
        check_out(0);
        counter_reset = 1'b0;
        idle(6);
        check_out(0);
        check_next(0);
        step(2'h0);
        reset_n = 1'b0;
        idle(20);
        check_out(0);
        reset_n = 1'b1;
        idle(8);
        step(2'h0);
        check_out(1);
        // feedback from count three shortens the cycle to three counts
        fb_on = 1'b1;
        step(2'h0);
        check_out(2);
        step(2'h0);
        check_out(0);
        fb_on = 1'b0;
        check_next(0);
        tally_and_finish();
    end
    initial begin
        idle(2000);
        err_total++;
        tally_and_finish();
    end
endmodule
bind djc_counter djc_checker djc_checker_i (.clock, .reset_n, .count_clock_pin, .count_enable_n,
    .counter_reset, .decoded_count_outputs, .ripple_carry_output);
`default_nettype wire
